// file: verilog/tx_synth_frontend_config_regs.sv
// Purpose : Transmit front-end and synthesizer calibration configuration
//           registers, trim registers and identification status registers.
// Assumes : The serial configuration port decodes frames into single-cycle
//           read and write strobes with an 8-bit address.
// Notes   : Read data is registered; it appears one cycle after the strobe.
`timescale 1ns/1ns

module tx_synth_frontend_config_regs
  import tx_cfg_pkg::*;
#(
  parameter logic [7:0] PART_NUMBER   = 8'h5a,  // Arbitrary value
  parameter logic [7:0] CHIP_REVISION = 8'h01   // Arbitrary value
) (
  input  wire logic       i_clk,               // Clock, 250 MHz
  input  wire logic       i_rst_n,             // Synchronous reset, active low
  input  wire logic       i_wr_en,             // Register write strobe
  input  wire logic       i_rd_en,             // Register read strobe
  input  wire logic [7:0] i_addr,              // Register address
  input  wire logic [7:0] i_wr_data,           // Write data
  input  wire logic       i_tbl_wr_en,         // Power table write strobe
  input  wire logic [0:0] i_tbl_wr_idx,        // Power table entry
  input  wire logic       i_sleep_enter,       // Pulse: entering sleep
  input  wire logic       i_pump_cal_done,     // Pulse: pump result valid
  input  wire logic [3:0] i_pump_cal_result,   // Pump calibration result
  input  wire logic       i_osc_cal_done,      // Pulse: oscillator results valid
  input  wire logic [4:0] i_osc_cur_result,    // Oscillator current result
  input  wire logic [5:0] i_cap_result,        // Capacitor array result
  output logic [7:0]      o_rd_data,           // Registered read data
  output logic            o_rd_valid,          // Read data valid pulse
  output logic [7:0]      o_amp_setting,       // Selected amplifier setting
  output logic [1:0]      o_lo_buffer_drive,   // LO buffer drive current
  output logic            o_pump_cal_stage_en, // Run pump calibration stage
  output logic [3:0]      o_pump_current,      // Pump output current code
  output logic            o_osc_core_high_sel, // High oscillator core
  output logic [4:0]      o_osc_current,       // Oscillator current code
  output logic [5:0]      o_cap_array,         // Coarse tuning capacitors
  output logic [6:0]      o_synth_cal_control, // Synthesizer cal control
  output logic            o_osc_select_cal_en  // Run oscillator select stage
);
  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [7:0] front_end_tx_config_r;
  logic [7:0] synth_cal_pump_r;
  logic [7:0] synth_cal_osc_current_r;
  logic [7:0] synth_cal_cap_array_r;
  logic [7:0] synth_cal_control_r;
  logic [7:0] reserved_trim_29_r;
  logic [7:0] reserved_trim_2a_r;
  logic [7:0] reserved_trim_2b_r;
  logic [7:0] misc_trim_a_r;
  logic [7:0] misc_trim_b_r;
  logic [7:0] misc_trim_c_r;
  logic [7:0] rd_data_nxt;

  tx_cfg_if #(.IDX_W(AMP_IDX_W)) tbl_if ();

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ----------------------------------------------------------------------
  // Front-end configuration
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      front_end_tx_config_r <= RST_FRONT_END_TX_CONFIG;
    end else if (i_wr_en && hit(i_addr, OFS_FRONT_END_TX_CONFIG)) begin
      front_end_tx_config_r <= i_wr_data & MASK_FRONT_END_TX_CONFIG;
    end
  end

  // ----------------------------------------------------------------------
  // Pump calibration: host write wins, else hardware result updates unless the enable field is 00
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      synth_cal_pump_r <= RST_SYNTH_CAL_PUMP;
    end else if (i_wr_en && hit(i_addr, OFS_SYNTH_CAL_PUMP)) begin
      synth_cal_pump_r <= i_wr_data & MASK_SYNTH_CAL_PUMP;
    end else if (i_pump_cal_done && (synth_cal_pump_r[PUMP_EN_LSB +: 2] != 2'b00)) begin
      synth_cal_pump_r[PUMP_RESULT_LSB +: 4] <= i_pump_cal_result;
    end
  end

  // ----------------------------------------------------------------------
  // Oscillator current and capacitor array results, synthesizer cal control
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      synth_cal_osc_current_r <= RST_SYNTH_CAL_OSC_CURRENT;
    end else if (i_wr_en && hit(i_addr, OFS_SYNTH_CAL_OSC_CURRENT)) begin
      synth_cal_osc_current_r <= i_wr_data & MASK_SYNTH_CAL_OSC_CURRENT;
    end else if (i_osc_cal_done) begin
      synth_cal_osc_current_r[OSC_CUR_LSB +: 5] <= i_osc_cur_result;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      synth_cal_cap_array_r <= RST_SYNTH_CAL_CAP_ARRAY;
    end else if (i_wr_en && hit(i_addr, OFS_SYNTH_CAL_CAP_ARRAY)) begin
      synth_cal_cap_array_r <= i_wr_data & MASK_SYNTH_CAL_CAP_ARRAY;
    end else if (i_osc_cal_done) begin
      synth_cal_cap_array_r <= {2'b00, i_cap_result};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      synth_cal_control_r <= RST_SYNTH_CAL_CONTROL;
    end else if (i_wr_en && hit(i_addr, OFS_SYNTH_CAL_CONTROL)) begin
      synth_cal_control_r <= i_wr_data & MASK_SYNTH_CAL_CONTROL;
    end
  end

  // ----------------------------------------------------------------------
  // Trim registers, reloaded on sleep entry
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_sleep_enter) begin
      reserved_trim_29_r <= RST_RESERVED_TRIM_29;
      reserved_trim_2a_r <= RST_RESERVED_TRIM_2A;
      reserved_trim_2b_r <= RST_RESERVED_TRIM_2B;
      misc_trim_a_r      <= RST_MISC_TRIM_A;
      misc_trim_b_r      <= RST_MISC_TRIM_B;
      misc_trim_c_r      <= RST_MISC_TRIM_C;
    end else if (i_wr_en) begin
      if (hit(i_addr, OFS_RESERVED_TRIM_29)) reserved_trim_29_r <= i_wr_data;
      if (hit(i_addr, OFS_RESERVED_TRIM_2A)) reserved_trim_2a_r <= i_wr_data;
      if (hit(i_addr, OFS_RESERVED_TRIM_2B)) reserved_trim_2b_r <= i_wr_data;
      if (hit(i_addr, OFS_MISC_TRIM_A)) misc_trim_a_r <= i_wr_data;
      if (hit(i_addr, OFS_MISC_TRIM_B)) misc_trim_b_r <= i_wr_data;
      if (hit(i_addr, OFS_MISC_TRIM_C)) misc_trim_c_r <= i_wr_data;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (i_addr)
      OFS_FRONT_END_TX_CONFIG:   rd_data_nxt = front_end_tx_config_r;
      OFS_SYNTH_CAL_PUMP:        rd_data_nxt = synth_cal_pump_r;
      OFS_SYNTH_CAL_OSC_CURRENT: rd_data_nxt = synth_cal_osc_current_r;
      OFS_SYNTH_CAL_CAP_ARRAY:   rd_data_nxt = synth_cal_cap_array_r;
      OFS_SYNTH_CAL_CONTROL:     rd_data_nxt = synth_cal_control_r;
      OFS_RESERVED_TRIM_29:      rd_data_nxt = reserved_trim_29_r;
      OFS_RESERVED_TRIM_2A:      rd_data_nxt = reserved_trim_2a_r;
      OFS_RESERVED_TRIM_2B:      rd_data_nxt = reserved_trim_2b_r;
      OFS_MISC_TRIM_A:           rd_data_nxt = misc_trim_a_r;
      OFS_MISC_TRIM_B:           rd_data_nxt = misc_trim_b_r;
      OFS_MISC_TRIM_C:           rd_data_nxt = misc_trim_c_r;
      OFS_PART_NUMBER_ID,
      OFS_PART_NUMBER_ALT:       rd_data_nxt = PART_NUMBER;
      OFS_CHIP_REVISION_ID,
      OFS_CHIP_REVISION_ALT:     rd_data_nxt = CHIP_REVISION;
      default:                   rd_data_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rd_data  <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= rd_data_nxt;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power table lookup
  // ----------------------------------------------------------------------
  assign tbl_if.amp_level_index = front_end_tx_config_r[AMP_IDX_LSB +: AMP_IDX_W];

  power_level_table #(.ENTRIES(POWER_TABLE_SIZE)) u_table (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_wr_en   (i_tbl_wr_en),
    .i_wr_idx  (i_tbl_wr_idx),
    .i_wr_data (i_wr_data),
    .tbl       (tbl_if.table_side)
  );

  // ----------------------------------------------------------------------
  // Registered control outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_amp_setting       <= 8'h00;
      o_lo_buffer_drive   <= RST_FRONT_END_TX_CONFIG[LO_DRIVE_LSB +: 2];
      o_pump_cal_stage_en <= (RST_SYNTH_CAL_PUMP[PUMP_EN_LSB +: 2] != 2'b00);
      o_pump_current      <= RST_SYNTH_CAL_PUMP[PUMP_RESULT_LSB +: 4];
      o_osc_core_high_sel <= RST_SYNTH_CAL_OSC_CURRENT[OSC_CORE_BIT];
      o_osc_current       <= RST_SYNTH_CAL_OSC_CURRENT[OSC_CUR_LSB +: 5];
      o_cap_array         <= RST_SYNTH_CAL_CAP_ARRAY[5:0];
      o_synth_cal_control <= RST_SYNTH_CAL_CONTROL[6:0];
      o_osc_select_cal_en <= RST_MISC_TRIM_C[OSC_SEL_EN_BIT];
    end else begin
      o_amp_setting       <= tbl_if.amp_setting;
      o_lo_buffer_drive   <= front_end_tx_config_r[LO_DRIVE_LSB +: 2];
      o_pump_cal_stage_en <= (synth_cal_pump_r[PUMP_EN_LSB +: 2] != 2'b00);
      o_pump_current      <= synth_cal_pump_r[PUMP_RESULT_LSB +: 4];
      o_osc_core_high_sel <= synth_cal_osc_current_r[OSC_CORE_BIT];
      o_osc_current       <= synth_cal_osc_current_r[OSC_CUR_LSB +: 5];
      o_cap_array         <= synth_cal_cap_array_r[5:0];
      o_synth_cal_control <= synth_cal_control_r[6:0];
      o_osc_select_cal_en <= misc_trim_c_r[OSC_SEL_EN_BIT];
    end
  end
endmodule : tx_synth_frontend_config_regs

// file: verilog/tx_cfg_pkg.sv
// Purpose : Shared constants for the transmit front-end and synthesizer
//           configuration register bank.
// Assumes : 8-bit registers addressed by an 8-bit register address.
// Notes   : Status registers also answer at their burst-space alias.
package tx_cfg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_FRONT_END_TX_CONFIG   = 8'h22;
  localparam logic [7:0] OFS_SYNTH_CAL_PUMP        = 8'h23;
  localparam logic [7:0] OFS_SYNTH_CAL_OSC_CURRENT = 8'h24;
  localparam logic [7:0] OFS_SYNTH_CAL_CAP_ARRAY   = 8'h25;
  localparam logic [7:0] OFS_SYNTH_CAL_CONTROL     = 8'h26;
  localparam logic [7:0] OFS_RESERVED_TRIM_29      = 8'h29;
  localparam logic [7:0] OFS_RESERVED_TRIM_2A      = 8'h2a;
  localparam logic [7:0] OFS_RESERVED_TRIM_2B      = 8'h2b;
  localparam logic [7:0] OFS_MISC_TRIM_A           = 8'h2c;
  localparam logic [7:0] OFS_MISC_TRIM_B           = 8'h2d;
  localparam logic [7:0] OFS_MISC_TRIM_C           = 8'h2e;
  localparam logic [7:0] OFS_PART_NUMBER_ID        = 8'h30;
  localparam logic [7:0] OFS_CHIP_REVISION_ID      = 8'h31;
  localparam logic [7:0] OFS_PART_NUMBER_ALT       = 8'hf0;
  localparam logic [7:0] OFS_CHIP_REVISION_ALT     = 8'hf1;
  localparam logic [7:0] OFS_VOLATILE_FIRST        = 8'h29;
  localparam logic [7:0] OFS_VOLATILE_LAST         = 8'h2e;

  // ----------------------------------------------------------------------
  // Writable bit masks (unused bits read zero)
  // ----------------------------------------------------------------------
  localparam logic [7:0] MASK_FRONT_END_TX_CONFIG   = 8'h37;
  localparam logic [7:0] MASK_SYNTH_CAL_PUMP        = 8'hff;
  localparam logic [7:0] MASK_SYNTH_CAL_OSC_CURRENT = 8'h3f;
  localparam logic [7:0] MASK_SYNTH_CAL_CAP_ARRAY   = 8'h3f;
  localparam logic [7:0] MASK_SYNTH_CAL_CONTROL     = 8'h7f;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_FRONT_END_TX_CONFIG   = 8'h10;
  localparam logic [7:0] RST_SYNTH_CAL_PUMP        = 8'ha9;
  localparam logic [7:0] RST_SYNTH_CAL_OSC_CURRENT = 8'h0a;
  localparam logic [7:0] RST_SYNTH_CAL_CAP_ARRAY   = 8'h20;
  localparam logic [7:0] RST_SYNTH_CAL_CONTROL     = 8'h0d;
  localparam logic [7:0] RST_RESERVED_TRIM_29      = 8'h59;
  localparam logic [7:0] RST_RESERVED_TRIM_2A      = 8'h7f;
  localparam logic [7:0] RST_RESERVED_TRIM_2B      = 8'h3f;
  localparam logic [7:0] RST_MISC_TRIM_A           = 8'h88;
  localparam logic [7:0] RST_MISC_TRIM_B           = 8'h31;
  localparam logic [7:0] RST_MISC_TRIM_C           = 8'h0b;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned AMP_IDX_LSB      = 0;
  localparam int unsigned AMP_IDX_W        = 3;
  localparam int unsigned LO_DRIVE_LSB     = 4;
  localparam int unsigned PUMP_RESULT_LSB  = 0;
  localparam int unsigned PUMP_EN_LSB      = 4;
  localparam int unsigned PUMP_CFG_LSB     = 6;
  localparam int unsigned OSC_CUR_LSB      = 0;
  localparam int unsigned OSC_CORE_BIT     = 5;
  localparam int unsigned OSC_SEL_EN_BIT   = 1;
  localparam int unsigned POWER_TABLE_SIZE = 2;
endpackage : tx_cfg_pkg

// file: verilog/tx_cfg_if.sv
// Purpose : Carries the decoded power-table selection between modules.
// Assumes : One power-table entry selected per cycle.
// Notes   : The top module drives the index, the table answers.
`timescale 1ns/1ns
interface tx_cfg_if #(
  parameter int unsigned IDX_W = 3
);
  logic [IDX_W-1:0] amp_level_index;  // Requested table index
  logic [7:0]       amp_setting;      // Selected amplifier setting
  logic             index_in_range;   // Index falls inside the table

  modport ctrl (output amp_level_index, input amp_setting, input index_in_range);
  modport table_side (input amp_level_index, output amp_setting, output index_in_range);
endinterface : tx_cfg_if

// file: verilog/power_level_table.sv
// Purpose : Small table of programmable amplifier settings, indexed by the
//           amplifier level index.
// Assumes : Entries are written by the host through the top module.
// Notes   : Out-of-range indexes select the last entry.
`timescale 1ns/1ns
module power_level_table
  import tx_cfg_pkg::*;
#(
  parameter int unsigned ENTRIES = POWER_TABLE_SIZE
) (
  input  wire logic       i_clk,      // Clock
  input  wire logic       i_rst_n,    // Synchronous reset, active low
  input  wire logic       i_wr_en,    // Write one table entry
  input  wire logic [0:0] i_wr_idx,   // Entry written
  input  wire logic [7:0] i_wr_data,  // Entry value
  tx_cfg_if.table_side    tbl         // Index in, setting out
);
  if (ENTRIES != 2) begin : g_entries_check
    $error("power_level_table supports two entries");
  end

  logic [7:0] entry_r [ENTRIES];

  // ----------------------------------------------------------------------
  // Entry storage
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < ENTRIES; i++) begin
        entry_r[i] <= 8'h00;
      end
    end else if (i_wr_en) begin
      entry_r[i_wr_idx] <= i_wr_data;
    end
  end

  // ----------------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------------
  always_comb begin
    tbl.index_in_range = (tbl.amp_level_index < 3'(ENTRIES));
    if (tbl.index_in_range) begin
      tbl.amp_setting = entry_r[tbl.amp_level_index[0]];
    end else begin
      tbl.amp_setting = entry_r[ENTRIES-1];
    end
  end
endmodule : power_level_table

// file: bench/tx_cfg_regs_sva.sv
// Purpose : Port-level checks of the configuration register bank.
// Assumes : Field outputs trail their register by one cycle.
// Notes   : Bound to the top module below.
`timescale 1ns/1ns
module tx_cfg_regs_sva
  import tx_cfg_pkg::*;
#(
  parameter logic [7:0] PART_NUMBER   = 8'h5a,  // Arbitrary value
  parameter logic [7:0] CHIP_REVISION = 8'h01   // Arbitrary value
) (
  input wire logic       i_clk,               // Clock
  input wire logic       i_rst_n,             // Reset
  input wire logic       i_wr_en,             // Write strobe
  input wire logic       i_rd_en,             // Read strobe
  input wire logic [7:0] i_addr,              // Address
  input wire logic [7:0] i_wr_data,           // Write data
  input wire logic       i_sleep_enter,       // Sleep pulse
  input wire logic       i_pump_cal_done,     // Pump result valid
  input wire logic [3:0] i_pump_cal_result,   // Pump result
  input wire logic       i_osc_cal_done,      // Osc results valid
  input wire logic [4:0] i_osc_cur_result,    // Osc current result
  input wire logic [5:0] i_cap_result,        // Cap array result
  input wire logic [7:0] o_rd_data,           // Read data
  input wire logic       o_rd_valid,          // Read valid
  input wire logic [1:0] o_lo_buffer_drive,   // LO drive
  input wire logic       o_pump_cal_stage_en, // Pump stage enable
  input wire logic [3:0] o_pump_current,      // Pump current
  input wire logic       o_osc_core_high_sel, // Core select
  input wire logic [4:0] o_osc_current,       // Osc current
  input wire logic [5:0] o_cap_array,         // Cap array
  input wire logic [6:0] o_synth_cal_control, // Synth control
  input wire logic       o_osc_select_cal_en  // Osc select stage
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence wr_at(logic [7:0] a);
    i_wr_en && i_addr == a;
  endsequence
  sequence pump_run;
    o_pump_cal_stage_en ##1 o_pump_current == $past(i_pump_cal_result, 2);
  endsequence
  sequence pump_skip;
    !o_pump_cal_stage_en ##1 $stable(o_pump_current);
  endsequence
  part_id_a: assert property (
    i_rd_en && i_addr inside {8'h30, 8'hf0} |=> o_rd_valid && o_rd_data == PART_NUMBER)
    else $error("part number read wrong");
  revision_id_a: assert property (
    i_rd_en && i_addr inside {8'h31, 8'hf1} |=> o_rd_valid && o_rd_data == CHIP_REVISION)
    else $error("revision read wrong");
  unused_zero_a: assert property (
    i_rd_en && i_addr inside {8'h22, 8'h24, 8'h25, 8'h27} |=> o_rd_data[7:6] == 2'h0)
    else $error("unused bits not zero");
  read_hold_a: assert property (!i_rd_en |=> !o_rd_valid && $stable(o_rd_data))
    else $error("read data moved without a read");
  lo_drive_a: assert property (
    wr_at(8'h22) |-> ##2 o_lo_buffer_drive == $past(i_wr_data[5:4], 2))
    else $error("lo drive not updated");
  pump_write_a: assert property (wr_at(8'h23) |-> ##2
    o_pump_cal_stage_en == ($past(i_wr_data[5:4], 2) != 2'h0)
    && o_pump_current == $past(i_wr_data[3:0], 2)) else $error("pump fields wrong");
  pump_load_a: assert property (
    i_pump_cal_done && !(i_wr_en && i_addr == 8'h23) |=> pump_run or pump_skip)
    else $error("pump result handling wrong");
  osc_write_a: assert property (wr_at(8'h24) |-> ##2
    o_osc_core_high_sel == $past(i_wr_data[5], 2) && o_osc_current == $past(i_wr_data[4:0], 2))
    else $error("osc fields wrong");
  osc_load_a: assert property (
    i_osc_cal_done && !(i_wr_en && i_addr inside {8'h24, 8'h25}) |-> ##2
    o_osc_current == $past(i_osc_cur_result, 2) && o_cap_array == $past(i_cap_result, 2))
    else $error("osc results not loaded");
  ctrl_write_a: assert property (
    wr_at(8'h26) |-> ##2 o_synth_cal_control == $past(i_wr_data[6:0], 2))
    else $error("synth control wrong");
  sleep_reload_a: assert property (i_sleep_enter |-> ##2 o_osc_select_cal_en)
    else $error("sleep reload missing");
  sel_cal_a: assert property (
    wr_at(8'h2e) ##0 !i_sleep_enter |-> ##2 o_osc_select_cal_en == $past(i_wr_data[1], 2))
    else $error("osc select enable wrong");
endmodule : tx_cfg_regs_sva

bind tx_synth_frontend_config_regs tx_cfg_regs_sva #(
  .PART_NUMBER(PART_NUMBER), .CHIP_REVISION(CHIP_REVISION)) tx_cfg_regs_sva_i (
  .i_clk, .i_rst_n, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data, .i_sleep_enter, .i_pump_cal_done,
  .i_pump_cal_result, .i_osc_cal_done, .i_osc_cur_result, .i_cap_result, .o_rd_data,
  .o_rd_valid, .o_lo_buffer_drive, .o_pump_cal_stage_en, .o_pump_current, .o_osc_core_high_sel,
  .o_osc_current, .o_cap_array, .o_synth_cal_control, .o_osc_select_cal_en);

// file: bench/host_port_model.sv
// Purpose : Host side of the configuration port: single-byte strobes.
// Assumes : Read data answers one cycle after the read strobe.
// Notes   : Released address and data lines show the inverse value.
`timescale 1ns/1ns
module host_port_model (
  input  wire logic       i_clk,        // Clock
  input  wire logic       i_rd_valid,   // Read valid
  input  wire logic [7:0] i_rd_data,    // Read data
  output logic            o_wr_en,      // Write strobe
  output logic            o_rd_en,      // Read strobe
  output logic [7:0]      o_addr,       // Address
  output logic [7:0]      o_wr_data,    // Write data
  output logic            o_tbl_wr_en,  // Table write strobe
  output logic [0:0]      o_tbl_wr_idx  // Table entry
);
  initial begin
    {o_wr_en, o_rd_en, o_tbl_wr_en, o_tbl_wr_idx} = 4'h0;
    {o_addr, o_wr_data} = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {o_wr_en, o_addr, o_wr_data} <= {1'b1, a, d};
    @(posedge i_clk);
    {o_wr_en, o_addr, o_wr_data} <= {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge i_clk);
    {o_rd_en, o_addr} <= {1'b1, a};
    @(posedge i_clk);
    {o_rd_en, o_addr} <= {1'b0, ~a};
    #1;
    v = i_rd_valid;
    d = i_rd_data;
  endtask : rd
  task automatic tbl(input logic [0:0] i, input logic [7:0] d);
    @(posedge i_clk);
    {o_tbl_wr_en, o_tbl_wr_idx, o_wr_data} <= {1'b1, i, d};
    @(posedge i_clk);
    {o_tbl_wr_en, o_wr_data} <= {1'b0, ~d};
  endtask : tbl
endmodule : host_port_model

// file: bench/tx_synth_frontend_config_regs_tb.sv
// Purpose : Self-checking bench for the configuration register bank.
// Assumes : Host model issues strobes; bench drives calibration events.
// Notes   : Random data from a fixed seed.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tx_synth_frontend_config_regs_tb;
  import tx_cfg_pkg::*;
  localparam logic [7:0] PN = 8'h3c;  // Arbitrary value
  localparam logic [7:0] CR = 8'h07;  // Arbitrary value
  logic       i_clk, i_rst_n, i_wr_en, i_rd_en, i_tbl_wr_en, i_sleep_enter, o_rd_valid, v;
  logic       i_pump_cal_done, i_osc_cal_done, o_pump_cal_stage_en, o_osc_core_high_sel;
  logic       o_osc_select_cal_en;
  logic [0:0] i_tbl_wr_idx;
  logic [1:0] o_lo_buffer_drive;
  logic [3:0] i_pump_cal_result, o_pump_current;
  logic [4:0] i_osc_cur_result, o_osc_current;
  logic [5:0] i_cap_result, o_cap_array;
  logic [6:0] o_synth_cal_control;
  logic [7:0] i_addr, i_wr_data, o_rd_data, o_amp_setting, a, dw, d, e0, e1;
  logic [7:0] addrs [16] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h29, 8'h2a, 8'h2b,
                             8'h2c, 8'h2d, 8'h2e, 8'h30, 8'h31, 8'hf0, 8'hf1, 8'h27};
  int         errors, samples_checked, cycles, seed;

  tx_synth_frontend_config_regs #(.PART_NUMBER(PN), .CHIP_REVISION(CR))
    tx_synth_frontend_config_regs_i (
    .i_clk, .i_rst_n, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data, .i_tbl_wr_en, .i_tbl_wr_idx,
    .i_sleep_enter, .i_pump_cal_done, .i_pump_cal_result, .i_osc_cal_done, .i_osc_cur_result,
    .i_cap_result, .o_rd_data, .o_rd_valid, .o_amp_setting, .o_lo_buffer_drive,
    .o_pump_cal_stage_en, .o_pump_current, .o_osc_core_high_sel, .o_osc_current, .o_cap_array,
    .o_synth_cal_control, .o_osc_select_cal_en);
  host_port_model host_port_model_i (
    .i_clk(i_clk), .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data), .o_wr_en(i_wr_en),
    .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wr_data(i_wr_data), .o_tbl_wr_en(i_tbl_wr_en),
    .o_tbl_wr_idx(i_tbl_wr_idx));

  function automatic logic [7:0] mask_of(input logic [7:0] x);
    case (x)
      8'h22: return 8'h37;
      8'h24, 8'h25: return 8'h3f;
      8'h26: return 8'h7f;
      8'h23, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction : mask_of
  function automatic logic [7:0] rst_of(input logic [7:0] x);
    case (x)
      8'h22: return 8'h10;  8'h23: return 8'ha9;  8'h24: return 8'h0a;  8'h25: return 8'h20;
      8'h26: return 8'h0d;  8'h29: return 8'h59;  8'h2a: return 8'h7f;  8'h2b: return 8'h3f;
      8'h2c: return 8'h88;  8'h2d: return 8'h31;  8'h2e: return 8'h0b;
      8'h30, 8'hf0: return PN;
      8'h31, 8'hf1: return CR;
      default: return 8'h00;
    endcase
  endfunction : rst_of
  task automatic hw_done(input logic p, input logic o);
    @(posedge i_clk);
    {i_pump_cal_done, i_osc_cal_done} <= {p, o};
    {i_pump_cal_result, i_osc_cur_result, i_cap_result} <= 15'($random(seed));
    @(posedge i_clk);
    {i_pump_cal_done, i_osc_cal_done} <= 2'h0;
  endtask : hw_done
  task automatic wrap_up();
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    {i_rst_n, i_sleep_enter, i_pump_cal_done, i_osc_cal_done} = 4'h0;
    {i_pump_cal_result, i_osc_cur_result, i_cap_result} = 15'h0000;
    seed = 37;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // ------------
    // Reset values, identification aliases, unmapped place
    // ------------
    foreach (addrs[k]) begin
      host_port_model_i.rd(addrs[k], d, v);
      `CHK("rst_read", rst_of(addrs[k]), d)
      `CHK("rd_valid", 1'b1, v)
    end
    // ------------
    // Random write then read back, read-only and unused bits kept
    // ------------
    repeat (40) begin
      a = addrs[$unsigned($random(seed)) % 16];
      dw = 8'($random(seed));
      host_port_model_i.wr(a, dw);
      host_port_model_i.rd(a, d, v);
      `CHK("readback", (dw & mask_of(a)) | (rst_of(a) & ~mask_of(a)), d)
    end
    // ------------
    // Sleep reload of the volatile trim registers
    // ------------
    for (int k = 5; k < 11; k++) host_port_model_i.wr(addrs[k], 8'h00);
    host_port_model_i.wr(8'h22, 8'h21);
    `CHK("sel_cal_off", 1'b0, o_osc_select_cal_en)
    @(posedge i_clk) i_sleep_enter <= 1'b1;
    @(posedge i_clk) i_sleep_enter <= 1'b0;
    for (int k = 5; k < 11; k++) begin
      host_port_model_i.rd(addrs[k], d, v);
      `CHK("sleep_reload", rst_of(addrs[k]), d)
    end
    host_port_model_i.rd(8'h22, d, v);
    `CHK("kept_in_sleep", 8'h21, d)
    `CHK("sel_cal_on", 1'b1, o_osc_select_cal_en)
    // ------------
    // Pump calibration for every enable code
    // ------------
    for (int pe = 0; pe < 4; pe++) begin
      host_port_model_i.wr(8'h23, {2'b10, 2'(pe), 4'h0});
      hw_done(1'b1, 1'b0);
      host_port_model_i.rd(8'h23, d, v);
      `CHK("pump_cal", {2'b10, 2'(pe), (pe == 0) ? 4'h0 : i_pump_cal_result}, d)
    end
    // ------------
    // Oscillator results and core select
    // ------------
    host_port_model_i.wr(8'h24, 8'h2a);
    hw_done(1'b0, 1'b1);
    host_port_model_i.rd(8'h24, d, v);
    `CHK("osc_cal", {3'b001, i_osc_cur_result}, d)
    host_port_model_i.rd(8'h25, d, v);
    `CHK("cap_cal", {2'b00, i_cap_result}, d)
    // ------------
    // Power table selection over every index
    // ------------
    e0 = 8'($random(seed));
    e1 = ~e0;
    host_port_model_i.tbl(1'b0, e0);
    host_port_model_i.tbl(1'b1, e1);
    for (int ix = 0; ix < 8; ix++) begin
      host_port_model_i.wr(8'h22, {2'b00, 2'(ix), 1'b0, 3'(ix)});
      repeat (2) @(posedge i_clk);
      #1;
      `CHK("amp_setting", (ix == 0) ? e0 : e1, o_amp_setting)
      `CHK("lo_drive", 2'(ix), o_lo_buffer_drive)
    end
    wrap_up();
  end
endmodule : tx_synth_frontend_config_regs_tb
